// >>> design/sob_pkg.sv
package sob_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OPTION = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // ----------------------------------------------------------------
  // Field positions and implemented-bit masks
  // ----------------------------------------------------------------
  localparam int OPT_FAULT_EN_BIT = 4;
  localparam int OPT_SW_OE_BIT = 3;
  localparam int OPT_WAIT_STOP_BIT = 1;
  localparam int OPT_SW_SEL_BIT = 0;
  localparam logic [7:0] OPT_IMPL_MASK = 8'h1B;
  localparam int BAUD_PRESC_LSB = 4;
  localparam int BAUD_RATE_LSB = 0;
  localparam logic [7:0] BAUD_IMPL_MASK = 8'h77;
  localparam int FLAG_RXFULL_BIT = 7;
  localparam int FLAG_TXEMPTY_BIT = 5;
  localparam int FLAG_FAULT_BIT = 4;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] OPTION_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sob_pkg

// >>> design/sob_top.sv
// Behaviour
// - Option bits 7,6,5,2 read zero
// - Slave: fault enable ignored, select pin input
// - Master without fault enable: release select pin
// - Master with fault enable: fault input or output
// - Output enable chooses fault input or auto output
// - Fault flag only for master fault-input low
// - Single-wire: output enable drives shared pin
// - Single-wire: master uses MOSI, slave MISO
// - Two-pin mode: single-wire enable ignored
// - Pin control bit zero selects single-wire
// - Wait-stop bit halts clocks in wait
// - Prescaler divides by field plus one
// - Prescaler output clocks the rate divider
// - Rate divider divides by two to field+1
// - Baud register accessible at any time
// - Flags bits 6,3,2,1,0 read zero
// - Writes to flags change nothing
// - Transfer completion sets receive full flag
`timescale 1ns/1ps
`default_nettype none
module sob_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic spi_enable,
  input wire logic master_select,
  input wire logic select_output_enable,
  input wire logic transfer_active,
  input wire logic transfer_done,
  input wire logic receive_clear,
  input wire logic fault_clear,
  input wire logic transmit_empty,
  input wire logic wait_mode,
  input wire logic shift_out,
  output logic shift_in,
  output logic slave_select_n,
  output logic bit_clock,
  output logic clocks_run,
  output logic irq,
  input wire logic ss_n_in,
  output logic ss_n_out,
  output logic ss_n_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe
);

  typedef struct packed {
    logic [7:0] aw_addr;
    logic aw_got;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] option;
    logic [7:0] baud;
    logic rx_full;
    logic fault;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    logic ss_meta;
    logic ss_sync;
    logic mosi_meta;
    logic mosi_sync;
    logic miso_meta;
    logic miso_sync;
    logic ss_out;
    logic ss_oe;
    logic mosi_out;
    logic mosi_oe;
    logic miso_out;
    logic miso_oe;
    logic shift_in;
    logic slave_select_n;
    logic [2:0] presc_cnt;
    logic [7:0] rate_cnt;
    logic bit_clock;
    logic clocks_run;
  } sob_state_s;

  sob_state_s st;
  sob_state_s next_st;

  logic [7:0] rd_addr;
  logic do_write;
  logic [2:0] presc_field;
  logic [2:0] rate_field;
  logic [7:0] half_period;
  logic master_on;
  logic single_wire;
  logic fault_en;
  logic fault_input;
  logic presc_tick;

  assign rd_addr = s_axi_araddr[7:0];
  assign do_write = st.aw_got && st.w_got && !st.bvalid;
  assign presc_field = st.baud[sob_pkg::BAUD_PRESC_LSB +: 3];
  assign rate_field = st.baud[sob_pkg::BAUD_RATE_LSB +: 3];
  assign half_period = 8'h01 << rate_field;
  assign master_on = spi_enable && master_select;
  assign single_wire = st.option[sob_pkg::OPT_SW_SEL_BIT];
  assign fault_en = st.option[sob_pkg::OPT_FAULT_EN_BIT];
  assign fault_input = master_on && fault_en && !select_output_enable;
  assign presc_tick = (st.presc_cnt == presc_field);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Two flip-flops before any pin is used
    next_st.ss_meta = ss_n_in;
    next_st.ss_sync = st.ss_meta;
    next_st.mosi_meta = mosi_in;
    next_st.mosi_sync = st.mosi_meta;
    next_st.miso_meta = miso_in;
    next_st.miso_sync = st.miso_meta;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_addr = s_axi_awaddr[7:0];
      next_st.aw_got = 1'b1;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_byte = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
      next_st.w_got = 1'b1;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = sob_pkg::RESP_OKAY;
      unique case (st.aw_addr)
        sob_pkg::OFS_OPTION: begin
          if (st.w_lane0) begin
            next_st.option = st.w_byte & sob_pkg::OPT_IMPL_MASK;
          end
        end
        sob_pkg::OFS_BAUD: begin
          if (st.w_lane0) begin
            next_st.baud = st.w_byte & sob_pkg::BAUD_IMPL_MASK;
          end
        end
        sob_pkg::OFS_FLAGS: begin
        end
        sob_pkg::OFS_IRQ_STATUS: begin
          if (st.w_lane0) begin
            next_st.irq_status = st.irq_status & ~st.w_byte[1:0];
          end
        end
        sob_pkg::OFS_IRQ_MASK: begin
          if (st.w_lane0) begin
            next_st.irq_mask = st.w_byte[1:0];
          end
        end
        default: begin
          next_st.bresp = sob_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;

    // Read channel: one read at a time, answer the cycle after
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = sob_pkg::RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      unique case (rd_addr)
        sob_pkg::OFS_OPTION: next_st.rdata[7:0] = st.option & sob_pkg::OPT_IMPL_MASK;
        sob_pkg::OFS_BAUD: next_st.rdata[7:0] = st.baud & sob_pkg::BAUD_IMPL_MASK;
        sob_pkg::OFS_FLAGS: begin
          next_st.rdata[sob_pkg::FLAG_RXFULL_BIT] = st.rx_full;
          next_st.rdata[sob_pkg::FLAG_TXEMPTY_BIT] = transmit_empty;
          next_st.rdata[sob_pkg::FLAG_FAULT_BIT] = st.fault;
        end
        sob_pkg::OFS_IRQ_STATUS: next_st.rdata[1:0] = st.irq_status;
        sob_pkg::OFS_IRQ_MASK: next_st.rdata[1:0] = st.irq_mask;
        default: next_st.rresp = sob_pkg::RESP_SLVERR;
      endcase
    end
    next_st.arready = !next_st.rvalid;

    // Flags: a set in the same cycle as a clear wins
    if (receive_clear) begin
      next_st.rx_full = 1'b0;
    end
    if (transfer_done) begin
      next_st.rx_full = 1'b1;
      next_st.irq_status[sob_pkg::IRQ_RX_BIT] = 1'b1;
    end
    if (fault_clear) begin
      next_st.fault = 1'b0;
    end
    if (fault_input && !st.ss_sync) begin
      next_st.fault = 1'b1;
      next_st.irq_status[sob_pkg::IRQ_FAULT_BIT] = 1'b1;
    end
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    next_st.ss_oe = 1'b0;
    next_st.ss_out = 1'b1;
    next_st.slave_select_n = st.ss_sync;
    if (master_on) begin
      next_st.slave_select_n = 1'b1;
      if (fault_en && select_output_enable) begin
        next_st.ss_oe = 1'b1;
        next_st.ss_out = !transfer_active;
      end
    end

    // Data pins; disabled module drives nothing
    next_st.mosi_oe = 1'b0;
    next_st.miso_oe = 1'b0;
    next_st.mosi_out = shift_out;
    next_st.miso_out = shift_out;
    next_st.shift_in = 1'b0;
    if (spi_enable) begin
      if (single_wire) begin
        // master on MOSI, slave on MISO
        if (master_select) begin
          next_st.mosi_oe = st.option[sob_pkg::OPT_SW_OE_BIT];
          next_st.shift_in = st.mosi_sync;
        end else begin
          next_st.miso_oe = st.option[sob_pkg::OPT_SW_OE_BIT];
          next_st.shift_in = st.miso_sync;
        end
      end else begin
        if (master_select) begin
          next_st.mosi_oe = 1'b1;
          next_st.shift_in = st.miso_sync;
        end else begin
          next_st.miso_oe = !st.ss_sync;
          next_st.shift_in = st.mosi_sync;
        end
      end
    end

    // clocks stop in wait when set
    next_st.clocks_run = !(wait_mode && st.option[sob_pkg::OPT_WAIT_STOP_BIT]);

    // Bit clock: counters freeze in wait so a transfer resumes intact
    if (!master_on) begin
      next_st.presc_cnt = 3'h0;
      next_st.rate_cnt = 8'h00;
      next_st.bit_clock = 1'b0;
    end else if (st.clocks_run) begin
      next_st.presc_cnt = presc_tick ? 3'h0 : st.presc_cnt + 3'h1;
      if (presc_tick) begin
        if (st.rate_cnt >= half_period - 8'h01) begin
          next_st.rate_cnt = 8'h00;
          next_st.bit_clock = !st.bit_clock;
        end else begin
          next_st.rate_cnt = st.rate_cnt + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.option <= sob_pkg::OPTION_RST;
      st.baud <= sob_pkg::BAUD_RST;
      st.irq_status <= sob_pkg::IRQ_RST;
      st.irq_mask <= sob_pkg::IRQ_RST;
      st.ss_meta <= 1'b1;
      st.ss_sync <= 1'b1;
      st.ss_out <= 1'b1;
      st.slave_select_n <= 1'b1;
      st.clocks_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign shift_in = st.shift_in;
  assign slave_select_n = st.slave_select_n;
  assign bit_clock = st.bit_clock;
  assign clocks_run = st.clocks_run;
  assign irq = st.irq;
  assign ss_n_out = st.ss_out;
  assign ss_n_oe = st.ss_oe;
  assign mosi_out = st.mosi_out;
  assign mosi_oe = st.mosi_oe;
  assign miso_out = st.miso_out;
  assign miso_oe = st.miso_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Helper: cycles since last bit clock toggle, valid only with stable setup
  logic [11:0] half_cnt;
  logic half_ok;
  always_ff @(posedge aclk) begin
    if (!aresetn || !master_on || !st.clocks_run || do_write) begin
      half_cnt <= 12'h000;
      half_ok <= 1'b0;
    end else if (st.bit_clock != next_st.bit_clock) begin
      half_cnt <= 12'h000;
      half_ok <= 1'b1;
    end else begin
      half_cnt <= half_cnt + 12'h001;
    end
  end

  sequence read_of(logic [7:0] a);
    s_axi_arvalid && st.arready && rd_addr == a;
  endsequence

  sequence master_fault_mode;
    master_on && fault_en;
  endsequence

  opt_reserved_zero_a: assert property (
    read_of(sob_pkg::OFS_OPTION) |=> s_axi_rvalid && s_axi_rdata[7:5] == 3'h0 && s_axi_rdata[2] == 1'b0)
    else $error("reserved option bits not zero");

  slave_ss_input_a: assert property (
    spi_enable && !master_select |=> !ss_n_oe && slave_select_n == $past(st.ss_sync))
    else $error("slave select pin not an input");

  master_gpio_ss_a: assert property (
    master_on && !fault_en |=> !ss_n_oe && slave_select_n)
    else $error("select pin not released");

  ss_auto_out_a: assert property (
    master_fault_mode ##0 select_output_enable |=> ss_n_oe && ss_n_out == !$past(transfer_active))
    else $error("automatic select output wrong");

  fault_cause_a: assert property (
    $rose(st.fault) |-> $past(fault_input) && !$past(st.ss_sync))
    else $error("fault flag set without cause");

  single_wire_pin_a: assert property (
    spi_enable && single_wire && master_select |=> mosi_oe == $past(st.option[sob_pkg::OPT_SW_OE_BIT]) && !miso_oe)
    else $error("single-wire master pin wrong");

  two_pin_mode_a: assert property (
    spi_enable && !single_wire && master_select |=> mosi_oe && !miso_oe)
    else $error("two-pin master pins wrong");

  wait_stop_a: assert property (
    wait_mode && st.option[sob_pkg::OPT_WAIT_STOP_BIT] |=> !clocks_run ##1 $stable(st.presc_cnt))
    else $error("clocks not stopped in wait");

  bit_half_period_a: assert property (
    half_ok && st.clocks_run && master_on && !do_write && st.bit_clock != next_st.bit_clock
      |-> half_cnt + 12'h001 == ({9'h000, presc_field} + 12'h001) * {4'h0, half_period})
    else $error("bit clock half period wrong");

  flags_zero_a: assert property (
    read_of(sob_pkg::OFS_FLAGS) |=> s_axi_rdata[6] == 1'b0 && s_axi_rdata[3:0] == 4'h0)
    else $error("reserved flag bits not zero");

  rx_full_set_a: assert property (
    transfer_done |=> st.rx_full [*1] ##0 st.irq_status[0])
    else $error("receive full not set");

endmodule : sob_top
`default_nettype wire

// >>> verification/sob_spi_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sob_spi_peer (
  input wire logic aclk,
  input wire logic peer_ss_low,
  input wire logic peer_drive,
  input wire logic peer_bit,
  input wire logic ss_n_out,
  input wire logic ss_n_oe,
  input wire logic mosi_out,
  input wire logic mosi_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  output logic ss_n_in,
  output logic mosi_in,
  output logic miso_in
);
  logic toggle = 1'b0;
  // Undriven data lines toggle so a missing driver never reads as a steady level
  always @(posedge aclk) begin
    toggle <= ~toggle;
  end
  // Select line has a pull-up; the peer pulls it low when it acts as a second master
  assign ss_n_in = ss_n_oe ? ss_n_out : ~peer_ss_low;
  assign mosi_in = mosi_oe ? mosi_out : (peer_drive ? peer_bit : toggle);
  assign miso_in = miso_oe ? miso_out : (peer_drive ? peer_bit : toggle);
endmodule : sob_spi_peer
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic spi_enable, master_select, select_output_enable, transfer_active, transfer_done;
  logic receive_clear, fault_clear, transmit_empty, wait_mode, shift_out;
  logic shift_in, slave_select_n, bit_clock, clocks_run, irq;
  logic ss_n_in, ss_n_out, ss_n_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
  logic peer_ss_low, peer_drive, peer_bit;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int bc_last = 0;
  int bc_per = 0;
  logic bc_prev = 1'b0;

  sob_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .spi_enable, .master_select, .select_output_enable, .transfer_active,
    .transfer_done, .receive_clear, .fault_clear, .transmit_empty, .wait_mode, .shift_out, .shift_in,
    .slave_select_n, .bit_clock, .clocks_run, .irq, .ss_n_in, .ss_n_out, .ss_n_oe, .mosi_in,
    .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe);
  sob_spi_peer i_peer (.aclk, .peer_ss_low, .peer_drive, .peer_bit, .ss_n_out, .ss_n_oe,
    .mosi_out, .mosi_oe, .miso_out, .miso_oe, .ss_n_in, .mosi_in, .miso_in);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Bit clock period in bus cycles, between consecutive rising edges
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    bc_prev <= bit_clock;
    if (bit_clock === 1'b1 && bc_prev === 1'b0) begin
      bc_per <= cyc - bc_last;
      bc_last <= cyc;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic hang(input int n);
    if (n >= 200) begin
      miscompares++;
      $display("ERROR %0t bus answer missing", $time);
      print_verdict();
    end
  endtask : hang

  // Bready and rready stay high, so the answer is taken at the edge it is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    hang(n);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    hang(n);
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chk({irq, ss_n_oe, clocks_run, bit_clock}, 4'h2, "reset pins");
    rd(sob_pkg::OFS_BAUD);
    chk(d, 32'h0, "baud reset");
    wr(sob_pkg::OFS_OPTION, 8'hFF);
    rd(sob_pkg::OFS_OPTION);
    chk(d, 32'h1B, "option bits");
    transfer_active <= 1'b1;
    wr(sob_pkg::OFS_BAUD, 8'hFF);
    rd(sob_pkg::OFS_BAUD);
    chk(d, 32'h77, "baud busy");
    transfer_active <= 1'b0;
    wr(sob_pkg::OFS_FLAGS, 8'hFF);
    chk(r, sob_pkg::RESP_OKAY, "flags write");
    rd(sob_pkg::OFS_FLAGS);
    chk(d, 32'h20, "flags bits");
    wr(8'h14, 8'h5A);
    chk(r, sob_pkg::RESP_SLVERR, "unmapped write");
    rd(8'h14);
    chk(r, sob_pkg::RESP_SLVERR, "unmapped read");
    wr(sob_pkg::OFS_OPTION, 8'h00);
  endtask : t_regs

  // Ascending divisors, so a counter never sits past a new smaller limit
  task automatic t_baud();
    logic [2:0] p[4] = '{3'd0, 3'd2, 3'd4, 3'd7};
    logic [2:0] q[4] = '{3'd0, 3'd1, 3'd3, 3'd7};
    int e;
    master_select <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      e = (p[i] + 1) * (2 << q[i]);
      wr(sob_pkg::OFS_BAUD, {1'b0, p[i], 1'b0, q[i]});
      wt(3 * e + 8);
      chk(bc_per, e, "bit clock period");
    end
  endtask : t_baud

  task automatic t_wait();
    wait_mode <= 1'b1;
    wr(sob_pkg::OFS_OPTION, 8'h02);
    wt(3);
    chk(clocks_run, 1'b0, "wait stop");
    wr(sob_pkg::OFS_OPTION, 8'h00);
    wt(3);
    chk(clocks_run, 1'b1, "wait run");
    wait_mode <= 1'b0;
  endtask : t_wait

  task automatic t_fault();
    wr(sob_pkg::OFS_IRQ_MASK, 8'h02);
    peer_ss_low <= 1'b1;
    wt(6);
    chk(ss_n_oe, 1'b0, "select released");
    rd(sob_pkg::OFS_FLAGS);
    chk(d, 32'h20, "no fault");
    wr(sob_pkg::OFS_OPTION, 8'h10);
    wt(6);
    chk(ss_n_oe, 1'b0, "fault input");
    rd(sob_pkg::OFS_FLAGS);
    chk(d, 32'h30, "fault set");
    chk(irq, 1'b1, "fault irq");
    peer_ss_low <= 1'b0;
    // Let the released select pass the synchroniser, else the set beats the clear
    wt(3);
    fault_clear <= 1'b1;
    @(posedge aclk);
    fault_clear <= 1'b0;
    rd(sob_pkg::OFS_FLAGS);
    chk(d, 32'h20, "fault cleared");
    wr(sob_pkg::OFS_IRQ_STATUS, 8'h02);
    wt(2);
    chk(irq, 1'b0, "irq cleared");
    select_output_enable <= 1'b1;
    transfer_active <= 1'b1;
    wt(3);
    chk({ss_n_oe, ss_n_out}, 2'b10, "auto select low");
    transfer_active <= 1'b0;
    wt(3);
    chk({ss_n_oe, ss_n_out}, 2'b11, "auto select high");
    select_output_enable <= 1'b0;
  endtask : t_fault

  task automatic t_slave();
    master_select <= 1'b0;
    peer_ss_low <= 1'b1;
    wt(6);
    chk({ss_n_oe, slave_select_n}, 2'b00, "slave select in");
    rd(sob_pkg::OFS_FLAGS);
    chk(d, 32'h20, "slave no fault");
    peer_ss_low <= 1'b0;
    wt(6);
    chk(slave_select_n, 1'b1, "slave deselect");
  endtask : t_slave

  task automatic t_pins();
    logic ms[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [7:0] op[6] = '{8'h00, 8'h08, 8'h09, 8'h01, 8'h09, 8'h01};
    logic [1:0] e[6] = '{2'b10, 2'b10, 2'b10, 2'b00, 2'b01, 2'b00};
    for (int i = 0; i < 6; i++) begin
      master_select <= ms[i];
      wr(sob_pkg::OFS_OPTION, op[i]);
      wt(3);
      chk({mosi_oe, miso_oe}, e[i], "data enables");
    end
    master_select <= 1'b1;
    peer_drive <= 1'b1;
    peer_bit <= 1'b1;
    wt(6);
    chk(shift_in, 1'b1, "shared pin in");
    peer_bit <= 1'b0;
    wt(6);
    chk(shift_in, 1'b0, "shared pin in");
    peer_drive <= 1'b0;
    shift_out <= 1'b1;
    wr(sob_pkg::OFS_OPTION, 8'h08);
    wt(3);
    chk({mosi_oe, mosi_out}, 2'b11, "two pin out");
    peer_drive <= 1'b1;
    peer_bit <= 1'b1;
    wt(6);
    chk(shift_in, 1'b1, "two pin in");
    peer_drive <= 1'b0;
    master_select <= 1'b0;
    wr(sob_pkg::OFS_OPTION, 8'h09);
    wt(3);
    chk({miso_oe, miso_out}, 2'b11, "shared pin out");
  endtask : t_pins

  task automatic t_rx();
    transfer_done <= 1'b1;
    @(posedge aclk);
    transfer_done <= 1'b0;
    wt(2);
    chk(irq, 1'b0, "rx masked");
    rd(sob_pkg::OFS_FLAGS);
    chk(d, 32'hA0, "rx full");
    wr(sob_pkg::OFS_FLAGS, 8'hFF);
    rd(sob_pkg::OFS_FLAGS);
    chk(d, 32'hA0, "flags write kept");
    wr(sob_pkg::OFS_IRQ_MASK, 8'h01);
    wt(2);
    chk(irq, 1'b1, "rx irq");
    wr(sob_pkg::OFS_IRQ_STATUS, 8'h01);
    wt(2);
    chk(irq, 1'b0, "rx irq clear");
    receive_clear <= 1'b1;
    @(posedge aclk);
    receive_clear <= 1'b0;
    rd(sob_pkg::OFS_FLAGS);
    chk(d, 32'h20, "rx cleared");
  endtask : t_rx

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {master_select, select_output_enable, transfer_active, transfer_done} = '0;
    {receive_clear, fault_clear, wait_mode, shift_out, peer_ss_low, peer_drive, peer_bit} = '0;
    spi_enable = 1'b1;
    transmit_empty = 1'b1;
    wt(5);
    aresetn <= 1'b1;
    wt(1);
    t_regs();
    t_baud();
    t_wait();
    t_fault();
    t_slave();
    t_pins();
    t_rx();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
